// ### sefcm_top.sv
// Overview of operation
// - Reset-occurred flag is set after every start-up.
// - Writing the reset-acknowledge bit clears the reset-occurred flag.
// - Streaming mode is forced while the reset-occurred flag stays set.
// - Acknowledging reset switches the device into event-driven mode.
// - Streaming opens a communication window after each measurement cycle.
// - Event-driven mode opens a window only when an event occurred.
// - Standalone mode opens no windows by itself.
// - In standalone, a host forced-communication request opens a window.
// - Event-mode bit selects event mode; cleared streaming-enable selects standalone.
// - Forced calibration command runs the calibration routine, may alter settings.
// - Zero-now recomputes angle offset so final angle centres interval 0.
// - Reseed loads long-term average with counts; far-off result starts calibration.
// - Calibration-running flag is high exactly while calibration runs.
// - Reset-occurred flag is set with all settings at default values; later writes can change settings while it stays set.
// - Event flags for power mode, calibration, touch, proximity, interval change.
// - Rotation direction reads 1 on interval increase, 0 on decrease.
// - Stationary after unchanged interval; low power only when stationary and dormant.
// - Proximity and touch flags set when delta exceeds their thresholds.
// - Fast-filter flag set while rapid rotation uses the faster filter.
// - Debounce flag high during rapid sampling after proximity crossing.
// - With release enabled, pulse press or release on touch entry by sign.
// - Masked events open no window but their flags are still set.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps
module sefcm_top
  import sefcm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sefcm_pkg::ADDR_W-1:0] paddr,
  input wire logic [sefcm_pkg::DATA_W-1:0] pwdata,
  output logic [sefcm_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic meas_done,
  input wire logic [15:0] raw_angle,
  input wire logic [15:0] touch_counts,
  output logic comm_window,
  output logic low_power,
  output logic calibration_running_flag,
  output logic press_pulse,
  output logic release_pulse,
  output logic [7:0] interval
);
  import sefcm_pkg::*;

  sefcm_link_if link_if ();

  logic [DATA_W-1:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic rst_flag_q;
  logic event_mode_q;
  logic stream_en_q;
  logic release_en_q;
  logic [EV_W-1:0] mask_q;
  logic [EV_W-1:0] evt_q;
  logic [EV_W-1:0] evt_new;
  logic [7:0] prox_thr_q;
  logic [7:0] touch_thr_q;
  logic [15:0] stat_time_q;
  logic [15:0] angle_off_q;
  logic [15:0] long_term_average;
  logic [7:0] interval_q;
  logic dir_q;
  logic chg_q;
  logic fast_q;
  logic stat_q;
  logic [15:0] stat_cnt_q;
  logic prox_q;
  logic touch_q;
  logic tdir_q;
  logic dormant_q;
  logic [15:0] dorm_cnt_q;
  logic [3:0] deb_cnt_q;
  logic press_q;
  logic release_q;
  logic lp_q;
  logic meas_q;
  logic window_q;
  sefcm_mode_e mode_q;
  sefcm_cal_e cal_q;
  logic [15:0] cal_cnt_q;
  logic cal_done_q;
  logic wr_en;
  logic forced_calibration_cmd;
  logic reseed_cmd;
  logic reseed_far;
  logic [15:0] final_angle;
  logic [7:0] new_int;
  logic [7:0] int_step;
  logic [7:0] step_mag;
  logic int_chg;
  logic [15:0] delta;
  logic [15:0] delta_mag;
  logic prox_n;
  logic touch_n;
  logic [15:0] seed_dev;
  logic [DATA_W-1:0] rd_mux;
  logic rd_hit;

  sefcm_link_sync u_link_sync (
    .pclk(pclk),
    .presetn(presetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .link(link_if.src)
  );

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign wr_en = psel & penable & pwrite & pready_q;
  assign forced_calibration_cmd = wr_en & hit(paddr, SYS_SETTINGS_OFF) & pwdata[SS_FORCE_CAL];
  assign reseed_cmd = wr_en & hit(paddr, TOUCH_CTRL_OFF) & pwdata[TC_RESEED];

  always_comb
  begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (paddr)
      SYS_FLAGS_OFF:
      begin
        rd_mux[SF_RESET] = rst_flag_q;
        rd_mux[SF_CAL_RUN] = calibration_running_flag;
        rd_mux[SF_MODE_LSB +: 3] = mode_q;
        rd_mux[SF_LOW_POWER] = lp_q;
      end
      EVENT_FLAGS_OFF: rd_mux[EV_W-1:0] = evt_q;
      HALL_FLAGS_OFF: rd_mux[3:0] = {fast_q, stat_q, dir_q, chg_q};
      TOUCH_FLAGS_OFF: rd_mux[6:0] = {release_q, press_q, (deb_cnt_q != 4'h0), tdir_q, dormant_q, touch_q, prox_q};
      SYS_SETTINGS_OFF:
      begin
        rd_mux[SS_EVENT_MODE] = event_mode_q;
        rd_mux[SS_STREAM_EN] = stream_en_q;
        rd_mux[SS_RELEASE_EN] = release_en_q;
      end
      EVENT_MASK_OFF: rd_mux[EV_W-1:0] = mask_q;
      HALL_CTRL_OFF: rd_mux = '0;
      TOUCH_CTRL_OFF: rd_mux = '0;
      INTERVAL_OFF: rd_mux[7:0] = interval_q;
      ANGLE_OFFSET_OFF: rd_mux[15:0] = angle_off_q;
      THRESH_OFF: rd_mux[15:0] = {touch_thr_q, prox_thr_q};
      STAT_TIME_OFF: rd_mux[15:0] = stat_time_q;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~rd_hit;
      prdata_q <= (psel & ~penable & ~pwrite) ? rd_mux : '0;
    end
  end

  // ----------------------------------------
  // Settings and reset flag
  // ----------------------------------------
  // flag and defaults share one reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_flag_q <= 1'b1;
      event_mode_q <= 1'b0;
      stream_en_q <= 1'b1;
      release_en_q <= 1'b0;
      mask_q <= EVENT_MASK_RST;
      prox_thr_q <= PROX_THR_RST;
      touch_thr_q <= TOUCH_THR_RST;
      stat_time_q <= STAT_TIME_RST;
    end
    else if (wr_en)
    begin
      if (hit(paddr, SYS_SETTINGS_OFF))
      begin
        event_mode_q <= pwdata[SS_EVENT_MODE];
        stream_en_q <= pwdata[SS_STREAM_EN];
        release_en_q <= pwdata[SS_RELEASE_EN];
        if (pwdata[SS_ACK])
        begin
          rst_flag_q <= 1'b0;
          event_mode_q <= 1'b1;
        end
      end
      if (hit(paddr, EVENT_MASK_OFF))
        mask_q <= pwdata[EV_W-1:0];
      if (hit(paddr, THRESH_OFF))
      begin
        prox_thr_q <= pwdata[7:0];
        touch_thr_q <= pwdata[15:8];
      end
      if (hit(paddr, STAT_TIME_OFF))
        stat_time_q <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // Communication mode
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= MODE_STREAM;
    else if (rst_flag_q)
      mode_q <= MODE_STREAM;
    else if (event_mode_q)
      mode_q <= MODE_EVENT;
    else if (!stream_en_q)
      mode_q <= MODE_STANDALONE;
    else
      mode_q <= MODE_STREAM;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meas_q <= 1'b0;
      window_q <= 1'b0;
    end
    else
    begin
      meas_q <= meas_done;
      case (mode_q)
        MODE_STREAM: window_q <= meas_q;
        MODE_EVENT: window_q <= |(evt_new & mask_q);
        MODE_STANDALONE: window_q <= link_if.start_det;
        default: window_q <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Calibration
  // ----------------------------------------
  assign seed_dev = (touch_counts > CAL_TARGET) ? touch_counts - CAL_TARGET : CAL_TARGET - touch_counts;
  assign reseed_far = reseed_cmd & (seed_dev > CAL_LIMIT);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cal_q <= CAL_IDLE;
      cal_cnt_q <= '0;
      cal_done_q <= 1'b0;
    end
    else
    begin
      cal_done_q <= 1'b0;
      case (cal_q)
        CAL_IDLE:
          if (forced_calibration_cmd | reseed_far)
          begin
            cal_q <= CAL_RUN;
            cal_cnt_q <= CAL_CYCLES;
          end
        CAL_RUN:
          if (cal_cnt_q == 16'h0001)
          begin
            cal_q <= CAL_IDLE;
            cal_cnt_q <= '0;
            cal_done_q <= 1'b1;
          end
          else
            cal_cnt_q <= cal_cnt_q - 16'h0001;
        default: cal_q <= CAL_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Angle, interval and rotation flags
  // ----------------------------------------
  assign final_angle = raw_angle - angle_off_q;
  assign new_int = final_angle[15:8];
  assign int_step = new_int - interval_q;
  assign step_mag = int_step[7] ? 8'h00 - int_step : int_step;
  assign int_chg = meas_done & (new_int != interval_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      angle_off_q <= '0;
    // centre final angle in interval 0
    else if (wr_en & hit(paddr, HALL_CTRL_OFF) & pwdata[HC_ZERO])
      angle_off_q <= raw_angle - INTERVAL_CENTRE;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      interval_q <= '0;
      dir_q <= 1'b0;
      chg_q <= 1'b0;
      fast_q <= 1'b0;
    end
    else if (meas_done)
    begin
      interval_q <= new_int;
      chg_q <= int_chg;
      if (int_chg)
        dir_q <= ~int_step[7];
      fast_q <= (step_mag >= FAST_STEP);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_cnt_q <= '0;
      stat_q <= 1'b0;
    end
    else if (int_chg)
    begin
      stat_cnt_q <= '0;
      stat_q <= 1'b0;
    end
    else if (meas_done)
    begin
      if (stat_cnt_q < stat_time_q)
        stat_cnt_q <= stat_cnt_q + 16'h0001;
      stat_q <= (stat_cnt_q >= stat_time_q);
    end
  end

  // ----------------------------------------
  // Touch channel
  // ----------------------------------------
  assign delta = touch_counts - long_term_average;
  assign delta_mag = delta[15] ? 16'h0000 - delta : delta;
  assign prox_n = delta_mag > {8'h00, prox_thr_q};
  assign touch_n = delta_mag > {8'h00, touch_thr_q};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      long_term_average <= '0;
    else if (reseed_cmd | cal_done_q)
      long_term_average <= touch_counts;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prox_q <= 1'b0;
      touch_q <= 1'b0;
      tdir_q <= 1'b0;
      deb_cnt_q <= '0;
      press_q <= 1'b0;
      release_q <= 1'b0;
    end
    else if (meas_done)
    begin
      prox_q <= prox_n;
      touch_q <= touch_n;
      tdir_q <= ~delta[15];
      if (prox_n & ~prox_q)
        deb_cnt_q <= DEBOUNCE_MEAS;
      else if (deb_cnt_q != 4'h0)
        deb_cnt_q <= deb_cnt_q - 4'h1;
      // press or release by delta sign
      press_q <= release_en_q & touch_n & ~touch_q & ~delta[15];
      release_q <= release_en_q & touch_n & ~touch_q & delta[15];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dorm_cnt_q <= '0;
      dormant_q <= 1'b0;
    end
    else if (meas_done)
    begin
      if (prox_n)
        dorm_cnt_q <= '0;
      else if (dorm_cnt_q < DORMANT_MEAS)
        dorm_cnt_q <= dorm_cnt_q + 16'h0001;
      dormant_q <= ~prox_n & (dorm_cnt_q >= DORMANT_MEAS);
    end
  end

  // ----------------------------------------
  // Power mode and event flags
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lp_q <= 1'b0;
    else
      lp_q <= stat_q & dormant_q;
  end

  always_comb
  begin
    evt_new = '0;
    evt_new[EV_PWR] = lp_q ^ (stat_q & dormant_q);
    evt_new[EV_CAL] = cal_done_q;
    evt_new[EV_TOUCH] = meas_done & (touch_n ^ touch_q);
    evt_new[EV_PROX] = meas_done & (prox_n ^ prox_q);
    evt_new[EV_INTERVAL] = int_chg;
  end

  // Write-one-to-clear, new event wins; mask not applied
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt_q <= '0;
    else if (wr_en & hit(paddr, EVENT_FLAGS_OFF))
      evt_q <= (evt_q & ~pwdata[EV_W-1:0]) | evt_new;
    else
      evt_q <= evt_q | evt_new;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign comm_window = window_q;
  assign low_power = lp_q;
  assign calibration_running_flag = cal_q[1];
  assign press_pulse = press_q;
  assign release_pulse = release_q;
  assign interval = interval_q;
endmodule

// ### sefcm_pkg.sv
package sefcm_pkg;

  // ----------------------------------------
  // Bus and register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] SYS_FLAGS_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] EVENT_FLAGS_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] HALL_FLAGS_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] TOUCH_FLAGS_OFF = 8'h0c;
  localparam logic [ADDR_W-1:0] SYS_SETTINGS_OFF = 8'h10;
  localparam logic [ADDR_W-1:0] EVENT_MASK_OFF = 8'h14;
  localparam logic [ADDR_W-1:0] HALL_CTRL_OFF = 8'h18;
  localparam logic [ADDR_W-1:0] TOUCH_CTRL_OFF = 8'h1c;
  localparam logic [ADDR_W-1:0] INTERVAL_OFF = 8'h20;
  localparam logic [ADDR_W-1:0] ANGLE_OFFSET_OFF = 8'h24;
  localparam logic [ADDR_W-1:0] THRESH_OFF = 8'h28;
  localparam logic [ADDR_W-1:0] STAT_TIME_OFF = 8'h2c;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SF_RESET = 0;
  localparam int SF_CAL_RUN = 1;
  localparam int SF_MODE_LSB = 2;
  localparam int SF_LOW_POWER = 5;
  localparam int EV_PWR = 0;
  localparam int EV_CAL = 1;
  localparam int EV_TOUCH = 2;
  localparam int EV_PROX = 3;
  localparam int EV_INTERVAL = 4;
  localparam int EV_W = 5;
  localparam int HF_CHANGE = 0;
  localparam int HF_DIR = 1;
  localparam int HF_STAT = 2;
  localparam int HF_FAST = 3;
  localparam int TF_PROX = 0;
  localparam int TF_TOUCH = 1;
  localparam int TF_DORMANT = 2;
  localparam int TF_DIR = 3;
  localparam int TF_DEBOUNCE = 4;
  localparam int TF_PRESS = 5;
  localparam int TF_RELEASE = 6;
  localparam int SS_ACK = 0;
  localparam int SS_EVENT_MODE = 1;
  localparam int SS_STREAM_EN = 2;
  localparam int SS_FORCE_CAL = 3;
  localparam int SS_RELEASE_EN = 4;
  localparam int HC_ZERO = 0;
  localparam int TC_RESEED = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [EV_W-1:0] EVENT_MASK_RST = 5'h1f;
  localparam logic [7:0] PROX_THR_RST = 8'h0a;
  localparam logic [7:0] TOUCH_THR_RST = 8'h28;
  localparam logic [15:0] STAT_TIME_RST = 16'h0032;

  // ----------------------------------------
  // Behaviour constants
  // ----------------------------------------
  localparam logic [15:0] INTERVAL_CENTRE = 16'h0080;
  localparam logic [7:0] FAST_STEP = 8'h02;
  localparam logic [15:0] DORMANT_MEAS = 16'h0064;
  localparam logic [3:0] DEBOUNCE_MEAS = 4'h4;
  localparam logic [15:0] CAL_TARGET = 16'h0200;
  localparam logic [15:0] CAL_LIMIT = 16'h0080;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int CAL_TIME_NS = 20000;
  localparam int CAL_CYCLES_I = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] CAL_CYCLES = CAL_CYCLES_I[15:0];

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_STREAM = 3'b001,
    MODE_EVENT = 3'b010,
    MODE_STANDALONE = 3'b100
  } sefcm_mode_e;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN = 2'b10
  } sefcm_cal_e;

endpackage

// ### sefcm_link_if.sv
`timescale 1ns/10ps
interface sefcm_link_if;
  logic scl_s;
  logic sda_s;
  logic start_det;
  modport src (output scl_s, output sda_s, output start_det);
  modport dst (input scl_s, input sda_s, input start_det);
endinterface

// ### sefcm_link_sync.sv
`timescale 1ns/10ps
module sefcm_link_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_in,
  input wire logic sda_in,
  sefcm_link_if.src link
);
  logic [1:0] pin_raw;
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] prev_q;
  logic start_q;

  assign pin_raw = {scl_in, sda_in};

  // ----------------------------------------
  // Two-stage synchronisers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta_q[gi] <= 1'b1;
          sync_q[gi] <= 1'b1;
          prev_q[gi] <= 1'b1;
        end
        else
        begin
          meta_q[gi] <= pin_raw[gi];
          sync_q[gi] <= meta_q[gi];
          prev_q[gi] <= sync_q[gi];
        end
      end
    end
  endgenerate

  // Start condition: data falls while clock high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_q <= 1'b0;
    else
      start_q <= sync_q[1] & prev_q[1] & prev_q[0] & ~sync_q[0];
  end

  assign link.scl_s = sync_q[1];
  assign link.sda_s = sync_q[0];
  assign link.start_det = start_q;
endmodule

// ### sefcm_top_properties.sv
`timescale 1ns/10ps
module sefcm_top_properties
  import sefcm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sefcm_pkg::ADDR_W-1:0] paddr,
  input wire logic [sefcm_pkg::DATA_W-1:0] pwdata,
  input wire logic [sefcm_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic meas_done,
  input wire logic comm_window,
  input wire logic calibration_running_flag,
  input wire logic press_pulse,
  input wire logic release_pulse,
  input wire logic [7:0] interval
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_acc;
  logic cal_req;
  logic ack_q;
  logic [10:0] cal_n_q;
  assign wr_acc = psel && penable && pwrite && pready;
  assign cal_req = wr_acc && (paddr == SYS_SETTINGS_OFF || paddr == TOUCH_CTRL_OFF);
  // ----------------------------------------
  // Ack seen and calibration length
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ack_q <= 1'h0;
    else if (wr_acc && paddr == SYS_SETTINGS_OFF && pwdata[SS_ACK])
      ack_q <= 1'h1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cal_n_q <= 11'h000;
    else if (calibration_running_flag)
      cal_n_q <= cal_n_q + 11'h001;
    else
      cal_n_q <= 11'h000;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  ready_after_setup_a: assert property (psel && !penable |=> pready && penable)
    else $error("no ready after setup");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == '0)
    else $error("read data outside access");
  cal_length_a: assert property ($fell(calibration_running_flag) |-> cal_n_q == 11'h3e8)
    else $error("calibration length wrong");
  cal_force_a: assert property (wr_acc && paddr == SYS_SETTINGS_OFF && pwdata[SS_FORCE_CAL] |=> calibration_running_flag)
    else $error("forced calibration not started");
  cal_cause_a: assert property ($rose(calibration_running_flag) |-> $past(cal_req))
    else $error("calibration without command");
  stream_window_a: assert property (meas_done && !ack_q && !wr_acc |-> ##2 comm_window)
    else $error("no streaming window");
  interval_meas_a: assert property ($changed(interval) |-> $past(meas_done) || $past(meas_done, 2))
    else $error("interval moved without measurement");
  press_excl_a: assert property (!(press_pulse && release_pulse))
    else $error("press and release together");
  cover property (meas_done ##2 comm_window);
  cover property ($fell(calibration_running_flag));
  cover property (pslverr);
  cover property (press_pulse);
endmodule

bind sefcm_top sefcm_top_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .meas_done, .comm_window, .calibration_running_flag, .press_pulse,
  .release_pulse, .interval);

// ### sefcm_i2c_host.sv
`timescale 1ns/10ps
module sefcm_i2c_host (
  output logic scl,
  output logic sda
);
  localparam int HALF_NS = 80;
  // ----------------------------------------
  // Idle bus, pulled high
  // ----------------------------------------
  initial
  begin
    scl = 1'h1;
    sda = 1'h1;
  end
  task automatic force_comm();
    #(HALF_NS) sda = 1'h0;
    #(HALF_NS) scl = 1'h0;
    #(HALF_NS) scl = 1'h1;
    #(HALF_NS) sda = 1'h1;
  endtask
endmodule

// ### sefcm_top_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("BAD %s exp %h got %h", nm, e, g); end end
module sefcm_top_tb;
  import sefcm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, meas_done, pready, pslverr, er, scl_w, sda_w;
  logic comm_window, low_power, calibration_running_flag, press_pulse, release_pulse;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [15:0] raw_angle, touch_counts, offs;
  logic [7:0] interval;
  int miscompares, n_tests, win_n, cal_n, k, seed;
  sefcm_i2c_host host (.scl(scl_w), .sda(sda_w));
  sefcm_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .scl_in(scl_w), .sda_in(sda_w), .meas_done, .raw_angle, .touch_counts, .comm_window, .low_power,
    .calibration_running_flag, .press_pulse, .release_pulse, .interval);
  // ----------------------------------------
  // Clock, counters, bus and model
  // ----------------------------------------
  initial
  begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end
  always @(negedge pclk)
  begin
    win_n += (comm_window === 1'h1);
    cal_n += (calibration_running_flag === 1'h1);
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do @(posedge pclk); while (pready !== 1'h1 && k++ < 100);
    if (k >= 100) miscompares++;
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0000_0000);
    `CHK(nm, e, rd)
  endtask
  task automatic meas(input int n);
    repeat (n)
    begin
      meas_done <= 1'h1;
      @(posedge pclk);
      meas_done <= 1'h0;
      repeat (5) @(posedge pclk);
    end
  endtask
  task automatic wchk(input int e);
    `CHK("windows", e, win_n)
    win_n = 0;
  endtask
  function automatic logic [7:0] ival(input logic [15:0] r);
    logic [15:0] t;
    t = r - offs;
    return t[15:8];
  endfunction
  task automatic rot(input logic [15:0] dr, input int w);
    raw_angle <= raw_angle + dr;
    meas(1);
    `CHK("interval", ival(raw_angle), interval)
    wchk(w);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #400000;
    miscompares++;
    tally_and_finish();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {psel, penable, pwrite, meas_done, presetn} = 5'h00;
    {paddr, pwdata} = '0;
    {miscompares, n_tests, win_n, cal_n} = '0;
    seed = 15053;
    raw_angle = 16'h1000;
    touch_counts = 16'h0200;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rchk("sys_flags", SYS_FLAGS_OFF, 32'h0000_0005);
    rchk("settings", SYS_SETTINGS_OFF, 32'h0000_0004);
    rchk("mask", EVENT_MASK_OFF, 32'h0000_001f);
    rchk("thresh", THRESH_OFF, 32'h0000_280a);
    rchk("stat_time", STAT_TIME_OFF, 32'h0000_0032);
    rchk("unmapped", 8'h40, 32'h0000_0000);
    `CHK("slverr", 1'h1, er)
    $display("reset test done");
    apb(1'h1, TOUCH_CTRL_OFF, 32'h0000_0001);
    apb(1'h1, SYS_SETTINGS_OFF, 32'h0000_0000);
    raw_angle <= $random(seed);
    apb(1'h1, HALL_CTRL_OFF, 32'h0000_0001);
    offs = raw_angle - 16'h0080;
    win_n = 0;
    meas(2);
    wchk(2);
    `CHK("zero", 8'h00, interval)
    $display("stream test done");
    apb(1'h1, SYS_SETTINGS_OFF, 32'h0000_0005);
    rchk("ack", SYS_FLAGS_OFF, 32'h0000_0008);
    meas(2);
    wchk(0);
    rot(16'h0100, 1);
    rchk("fwd", HALL_FLAGS_OFF, 32'h0000_0003);
    rot(16'hfd00, 1);
    rchk("rev", HALL_FLAGS_OFF, 32'h0000_0009);
    apb(1'h1, EVENT_MASK_OFF, 32'h0000_0000);
    apb(1'h1, EVENT_FLAGS_OFF, 32'h0000_001f);
    rot(16'h0100, 0);
    apb(1'h0, EVENT_FLAGS_OFF, 32'h0000_0000);
    `CHK("masked", 1'h1, rd[EV_INTERVAL])
    $display("event test done");
    apb(1'h1, EVENT_MASK_OFF, 32'h0000_001f);
    apb(1'h1, SYS_SETTINGS_OFF, 32'h0000_0000);
    rchk("alone", SYS_FLAGS_OFF, 32'h0000_0010);
    rot(16'h0200, 0);
    host.force_comm();
    repeat (10) @(posedge pclk);
    wchk(1);
    apb(1'h1, SYS_SETTINGS_OFF, 32'h0000_0004);
    rchk("stream", SYS_FLAGS_OFF, 32'h0000_0004);
    meas(1);
    wchk(1);
    $display("mode test done");
    apb(1'h1, STAT_TIME_OFF, 32'h0000_0002);
    meas(101);
    `CHK("low_power", 1'h1, low_power)
    apb(1'h0, EVENT_FLAGS_OFF, 32'h0000_0000);
    `CHK("pwr_event", 1'h1, rd[EV_PWR])
    cal_n = 0;
    apb(1'h1, SYS_SETTINGS_OFF, 32'h0000_000c);
    repeat (1100) @(posedge pclk);
    `CHK("cal_len", 1000, cal_n)
    apb(1'h0, EVENT_FLAGS_OFF, 32'h0000_0000);
    `CHK("cal_event", 1'h1, rd[EV_CAL])
    $display("power and calibration test done");
    apb(1'h1, SYS_SETTINGS_OFF, 32'h0000_0014);
    touch_counts <= 16'h0230;
    meas(1);
    `CHK("press", 1'h1, press_pulse)
    apb(1'h0, TOUCH_FLAGS_OFF, 32'h0000_0000);
    `CHK("prox_touch", 2'h3, rd[1:0])
    `CHK("debounce", 1'h1, rd[TF_DEBOUNCE])
    meas(5);
    apb(1'h0, TOUCH_FLAGS_OFF, 32'h0000_0000);
    `CHK("debounce_end", 1'h0, rd[TF_DEBOUNCE])
    touch_counts <= 16'h0200;
    meas(1);
    touch_counts <= 16'h01d0;
    meas(1);
    `CHK("release", 1'h1, release_pulse)
    touch_counts <= 16'h0300;
    apb(1'h1, TOUCH_CTRL_OFF, 32'h0000_0001);
    `CHK("reseed_cal", 1'h1, calibration_running_flag)
    $display("touch test done");
    tally_and_finish();
  end
endmodule
